// ==== pog_operator.sv ====
// Contract
// - toggling force bit starts single-shot trip
// - toggling force bit starts per-cycle trip
// - per-cycle trip ends at selected timer events
// - toggling clear bit cancels single-shot trip
// - trip status flags follow hardware trip state
// - stamp pending flag set on write, cleared on load
// - stamp loads per method, bit3 blocks loading
// - trigger sources selected immediately, four means none
// - action configuration loads per its method
// - trigger toggle applies one-time force level
// - held force level: one low, two high
// - held force loads per six-bit method
// - compare events when timer equals active stamp
// - two-bit action per event and direction
// - delay counts clock or prescaled tick
// - dual-edge mode puts both delays on B
// - delays load from shadows per method
// - chopper inverts inputs and outputs on request
// - first burst pulse lasts programmed number of divider ticks
// - carrier period is eight ticks of divider plus one clocks
// - chopper disabled passes inputs unchanged
// - carrier duty is duty field over eight
`timescale 1ns/10ps
`default_nettype none
`include "pog_params.svh"

module pog_operator (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic [31:0]             regRdata,
    input  wire pog_pkg::pog_timer_s timerIn,
    output logic                    operatorOutA,
    output logic                    operatorOutB,
    output logic                    compareAEvent,
    output logic                    compareBEvent,
    output logic                    singleTripActive,
    output logic                    perCycleTripActive
);
    import pog_pkg::*;

    pog_state_s st_r;
    pog_state_s st_nxt;
    logic [1:0] stampWr;
    logic [1:0] osToggle;
    logic       singleToggle;
    logic       cycleToggle;
    logic       clearToggle;
    logic       trigZero;
    logic       trigOne;
    logic [1:0] stampLoad;
    logic [5:0] evUp;
    logic [1:0] genFinal;
    logic       chTick;
    logic       redIn;
    logic       fedIn;
    logic       rising_edge_delay;
    logic       fed;
    logic       dtTick;
    logic [1:0] pin;
    logic [1:0] dtOut;
    logic [1:0] cin;

    // widen a four-bit load method to the six-bit layout
    function automatic logic [5:0] widen(input logic [3:0] m);
        widen = {m[3], m[2], 2'h0, m[1:0]};
    endfunction : widen

    // load now? method zero is immediate, top bit blocks the load
    function automatic logic loadNow(input logic [5:0] m, input logic [4:0] ev);
        loadNow = !m[5] && (m[4:0] == 5'h00 || |(m[4:0] & ev));
    endfunction : loadNow

    // apply a two-bit action code to a level
    function automatic logic applyAct(input logic cur, input logic [1:0] a);
        if (a == `POG_LVL_LOW) begin
            applyAct = 1'b0;
        end else if (a == `POG_LVL_HIGH) begin
            applyAct = 1'b1;
        end else if (a == `POG_ACT_TOGGLE) begin
            applyAct = ~cur;
        end else begin
            applyAct = cur;
        end
    endfunction : applyAct

    // pick a trigger source: faults, sync, or nothing
    function automatic logic pickSrc(input logic [2:0] sel, input pog_timer_s t);
        if (sel < `POG_SRC_SYNC) begin
            pickSrc = t.faultInput[sel[1:0]];
        end else if (sel == `POG_SRC_SYNC) begin
            pickSrc = t.syncTaken;
        end else begin
            pickSrc = 1'b0;
        end
    endfunction : pickSrc

    // all next-state logic in one process
    always_comb begin
        logic [4:0]  ev;
        logic        wr;
        logic        g;
        logic [1:0]  held;
        logic [1:0]  lvl;
        logic [15:0] dly;
        st_nxt = st_r;
        wr = regWrite;
        ev = {timerIn.syncTaken, 2'h0, timerIn.periodEvent, timerIn.zeroEvent};
        g = 1'b0;
        held = 2'h0;
        lvl = 2'h0;
        dly = 16'h0000;

        // toggles are detected against the stored bit at write time
        singleToggle = wr && regAddr == `POG_OFF_FH_CTRL
            && regWdata[`POG_FH_FORCE_SINGLE] != st_r.fhCtrl[`POG_FH_FORCE_SINGLE];
        cycleToggle = wr && regAddr == `POG_OFF_FH_CTRL
            && regWdata[`POG_FH_FORCE_CYCLE] != st_r.fhCtrl[`POG_FH_FORCE_CYCLE];
        clearToggle = wr && regAddr == `POG_OFF_FH_CTRL
            && regWdata[`POG_FH_CLEAR_SINGLE] != st_r.fhCtrl[`POG_FH_CLEAR_SINGLE];
        for (int i = 0; i < 2; i++) begin
            osToggle[i] = wr && regAddr == `POG_OFF_FORCE
                && regWdata[`POG_OS_TRIG_BASE + `POG_OS_STRIDE * i]
                != st_r.forceCfg[`POG_OS_TRIG_BASE + `POG_OS_STRIDE * i];
        end
        stampWr[0] = wr && regAddr == `POG_OFF_STAMP_A;
        stampWr[1] = wr && regAddr == `POG_OFF_STAMP_B;

        // register writes; if-else decode, read-only bits are not writable
        if (wr && regAddr == `POG_OFF_FH_CTRL) begin
            st_nxt.fhCtrl = regWdata[`POG_FH_CTRL];
        end else if (wr && regAddr == `POG_OFF_STAMP_CTRL) begin
            st_nxt.stampWhen = regWdata[`POG_STAMP_WHEN];
        end else if (wr && regAddr == `POG_OFF_SRC) begin
            st_nxt.srcCfg = regWdata[`POG_SRC_CFG];
        end else if (wr && regAddr == `POG_OFF_FORCE) begin
            st_nxt.forceCfg = regWdata[`POG_FORCE];
        end else if (wr && regAddr == `POG_OFF_ACT_A) begin
            st_nxt.actShadow[0] = regWdata[`POG_ACT];
        end else if (wr && regAddr == `POG_OFF_ACT_B) begin
            st_nxt.actShadow[1] = regWdata[`POG_ACT];
        end else if (wr && regAddr == `POG_OFF_DT_CFG) begin
            st_nxt.dtCfg = regWdata[`POG_DT_CFG];
        end else if (wr && regAddr == `POG_OFF_DT_FALL) begin
            st_nxt.delayShadow[1] = regWdata[15:0];
        end else if (wr && regAddr == `POG_OFF_DT_RISE) begin
            st_nxt.delayShadow[0] = regWdata[15:0];
        end else if (wr && regAddr == `POG_OFF_CHOP) begin
            st_nxt.chCfg = regWdata[`POG_CH_CFG];
        end

        // fault trips; a start in the same cycle as an end wins
        if (singleToggle) begin
            st_nxt.singleTripActive = 1'b1;
        end else if (clearToggle) begin
            st_nxt.singleTripActive = 1'b0;
        end
        if (cycleToggle) begin
            st_nxt.perCycleTripActive = 1'b1;
        end else if ((st_r.fhCtrl[`POG_FH_REF_ZERO] && timerIn.zeroEvent)
                || (st_r.fhCtrl[`POG_FH_REF_PERIOD] && timerIn.periodEvent)) begin
            st_nxt.perCycleTripActive = 1'b0;
        end

        // time stamps: shadow written by software, active by the method
        for (int i = 0; i < 2; i++) begin
            stampLoad[i] = st_r.stampPending[i] && loadNow(widen(
                st_r.stampWhen[i * `POG_STAMP_WHEN_W +: `POG_STAMP_WHEN_W]), ev);
            if (stampLoad[i]) begin
                st_nxt.stampActive[i] = st_r.stampShadow[i];
            end
            if (stampWr[i]) begin
                st_nxt.stampShadow[i] = regWdata[15:0];
                st_nxt.stampPending[i] = 1'b1;
            end else if (stampLoad[i]) begin
                st_nxt.stampPending[i] = 1'b0;
            end
        end

        // compare events against the active stamps
        st_nxt.cmpEvent[0] = timerIn.value == st_r.stampActive[0];
        st_nxt.cmpEvent[1] = timerIn.value == st_r.stampActive[1];
        trigZero = pickSrc(st_r.srcCfg[`POG_SRC_T0], timerIn);
        trigOne = pickSrc(st_r.srcCfg[`POG_SRC_T1], timerIn);
        evUp = {trigOne, trigZero, st_nxt.cmpEvent[1], st_nxt.cmpEvent[0],
                timerIn.periodEvent, timerIn.zeroEvent};

        // action tables and held force move to active by their methods
        if (loadNow(widen(st_r.srcCfg[`POG_SRC_WHEN]), ev)) begin
            st_nxt.actActive = st_r.actShadow;
        end
        if (loadNow(st_r.forceCfg[`POG_HELD_WHEN], {timerIn.syncTaken, evUp[3:0]})) begin
            st_nxt.heldActive = st_r.forceCfg[`POG_HELD_BASE +: 4];
        end

        // generator: later events in the table take priority
        for (int i = 0; i < 2; i++) begin
            g = st_r.genOut[i];
            for (int e = 0; e < 6; e++) begin
                if (evUp[e]) begin
                    g = applyAct(g, st_r.actActive[i][(timerIn.countsDown
                        ? `POG_ACT_DOWN : 0) + 2 * e +: 2]);
                end
            end
            lvl = regWdata[`POG_OS_TRIG_BASE + `POG_OS_STRIDE * i + 1 +: 2];
            if (osToggle[i] && (lvl == `POG_LVL_LOW || lvl == `POG_LVL_HIGH)) begin
                g = lvl[1];
            end
            if (st_r.singleTripActive || st_r.perCycleTripActive) begin
                g = 1'b0; // tripped: both outputs parked low
            end
            st_nxt.genOut[i] = g;
            held = st_r.heldActive[2 * i +: 2];
            if (held == `POG_LVL_LOW || held == `POG_LVL_HIGH) begin
                genFinal[i] = held[1];
            end else begin
                genFinal[i] = st_r.genOut[i];
            end
        end

        // dead time: path 0 delays rising edges, path 1 falling edges
        for (int p = 0; p < 2; p++) begin
            if (loadNow(widen(p == 0 ? st_r.dtCfg[`POG_DT_RISE_WHEN]
                    : st_r.dtCfg[`POG_DT_FALL_WHEN]), ev)) begin
                st_nxt.delayActive[p] = st_r.delayShadow[p];
            end
        end
        dtTick = st_r.dtCfg[`POG_DT_CLK_SEL] ? timerIn.prescaledTick : 1'b1;
        redIn = st_r.dtCfg[`POG_DT_RISE_SRC] ? genFinal[1] : genFinal[0];
        rising_edge_delay = st_r.delayOut[0];
        fedIn = st_r.dtCfg[`POG_DT_DEB] ? rising_edge_delay
            : (st_r.dtCfg[`POG_DT_FALL_SRC] ? genFinal[1] : genFinal[0]);
        fed = ~st_r.delayOut[1];
        pin = {~fedIn, redIn};
        for (int p = 0; p < 2; p++) begin
            dly = st_r.delayActive[p];
            if (!pin[p]) begin
                st_nxt.delayCnt[p] = 16'h0000;
                st_nxt.delayOut[p] = 1'b0;
            end else if (st_r.delayCnt[p] >= dly) begin
                st_nxt.delayOut[p] = 1'b1;
            end else begin
                st_nxt.delayCnt[p] = st_r.delayCnt[p] + {15'h0000, dtTick};
            end
        end
        rising_edge_delay = rising_edge_delay ^ st_r.dtCfg[`POG_DT_RISE_INV];
        fed = fed ^ st_r.dtCfg[`POG_DT_FALL_INV];
        dtOut[0] = st_r.dtCfg[`POG_DT_BYP_A]
            ? (st_r.dtCfg[`POG_DT_SWAP_A] ? genFinal[1] : genFinal[0]) : rising_edge_delay;
        dtOut[1] = st_r.dtCfg[`POG_DT_BYP_B]
            ? (st_r.dtCfg[`POG_DT_SWAP_B] ? genFinal[0] : genFinal[1]) : fed;

        // chopper: divider gives the carrier tick, phase gives duty
        chTick = st_r.preCnt == st_r.chCfg[`POG_CH_DIV];
        st_nxt.preCnt = chTick ? 4'h0 : st_r.preCnt + 4'h1;
        if (chTick) begin
            st_nxt.phase = st_r.phase + 3'h1;
        end
        cin = dtOut ^ {2{st_r.chCfg[`POG_CH_IN_INV]}};
        st_nxt.chInPrev = cin;
        for (int i = 0; i < 2; i++) begin
            if (cin[i] && !st_r.chInPrev[i]) begin
                st_nxt.firstCnt[i] = st_r.chCfg[`POG_CH_FIRST];
            end else if (chTick && st_r.firstCnt[i] != 4'h0) begin
                st_nxt.firstCnt[i] = st_r.firstCnt[i] - 4'h1;
            end
            if (!st_r.chCfg[`POG_CH_EN]) begin
                st_nxt.pwmOut[i] = dtOut[i];
            end else begin
                st_nxt.pwmOut[i] = st_r.chCfg[`POG_CH_OUT_INV] ^ (cin[i]
                    && ((cin[i] && !st_r.chInPrev[i]) || st_r.firstCnt[i] != 4'h0
                    || st_r.phase < st_r.chCfg[`POG_CH_DUTY]));
            end
        end

        // read data stands in the cycle after the strobe only
        st_nxt.rdata = 32'h0000_0000;
        if (regRead && regAddr == `POG_OFF_FH_CTRL) begin
            st_nxt.rdata = {27'h0, st_r.fhCtrl};
        end else if (regRead && regAddr == `POG_OFF_FH_STATE) begin
            st_nxt.rdata = {30'h0, st_r.perCycleTripActive, st_r.singleTripActive};
        end else if (regRead && regAddr == `POG_OFF_STAMP_CTRL) begin
            st_nxt.rdata = {22'h0, st_r.stampPending, st_r.stampWhen};
        end else if (regRead && regAddr == `POG_OFF_STAMP_A) begin
            st_nxt.rdata = {16'h0, st_r.stampShadow[0]};
        end else if (regRead && regAddr == `POG_OFF_STAMP_B) begin
            st_nxt.rdata = {16'h0, st_r.stampShadow[1]};
        end else if (regRead && regAddr == `POG_OFF_SRC) begin
            st_nxt.rdata = {22'h0, st_r.srcCfg};
        end else if (regRead && regAddr == `POG_OFF_FORCE) begin
            st_nxt.rdata = {16'h0, st_r.forceCfg};
        end else if (regRead && regAddr == `POG_OFF_ACT_A) begin
            st_nxt.rdata = {8'h0, st_r.actShadow[0]};
        end else if (regRead && regAddr == `POG_OFF_ACT_B) begin
            st_nxt.rdata = {8'h0, st_r.actShadow[1]};
        end else if (regRead && regAddr == `POG_OFF_DT_CFG) begin
            st_nxt.rdata = {14'h0, st_r.dtCfg};
        end else if (regRead && regAddr == `POG_OFF_DT_FALL) begin
            st_nxt.rdata = {16'h0, st_r.delayShadow[1]};
        end else if (regRead && regAddr == `POG_OFF_DT_RISE) begin
            st_nxt.rdata = {16'h0, st_r.delayShadow[0]};
        end else if (regRead && regAddr == `POG_OFF_CHOP) begin
            st_nxt.rdata = {18'h0, st_r.chCfg};
        end
    end

    // single state register; dead-time bypass bits come up set
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.dtCfg <= `POG_DT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign regRdata = st_r.rdata;
    assign operatorOutA = st_r.pwmOut[0];
    assign operatorOutB = st_r.pwmOut[1];
    assign compareAEvent = st_r.cmpEvent[0];
    assign compareBEvent = st_r.cmpEvent[1];
    assign singleTripActive = st_r.singleTripActive;
    assign perCycleTripActive = st_r.perCycleTripActive;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_toggle_then_active;
        singleToggle ##1 singleTripActive;
    endsequence
    property p_single_start;
        singleToggle |-> s_toggle_then_active;
    endproperty
    a_single_start: assert property (p_single_start)
        else $error("single trip not started");
    property p_single_clear;
        clearToggle && !singleToggle |=> !singleTripActive;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single trip not cleared");
    property p_cycle_start;
        cycleToggle |=> perCycleTripActive;
    endproperty
    a_cycle_start: assert property (p_cycle_start)
        else $error("per-cycle trip not started");
    property p_cycle_refresh;
        perCycleTripActive && !cycleToggle && timerIn.zeroEvent
            && st_r.fhCtrl[`POG_FH_REF_ZERO] |=> !perCycleTripActive;
    endproperty
    a_cycle_refresh: assert property (p_cycle_refresh)
        else $error("per-cycle trip not ended");
    property p_pending_set;
        stampWr[0] |=> st_r.stampPending[0] && st_r.stampShadow[0] == $past(regWdata[15:0]);
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("stamp A pending not set");
    property p_stamp_now;
        st_r.stampPending[0] && st_r.stampWhen[3:0] == 4'h0 && !stampWr[0]
            |=> !st_r.stampPending[0] && st_r.stampActive[0] == $past(st_r.stampShadow[0]);
    endproperty
    a_stamp_now: assert property (p_stamp_now)
        else $error("immediate stamp load missed");
    property p_compare;
        timerIn.value == st_r.stampActive[1] |=> compareBEvent;
    endproperty
    a_compare: assert property (p_compare)
        else $error("compare B event missed");
    property p_no_source;
        st_r.srcCfg[`POG_SRC_T0] == 3'h4 |-> !trigZero;
    endproperty
    a_no_source: assert property (p_no_source)
        else $error("trigger fired with no source");
    property p_held_low;
        st_r.heldActive[1:0] == `POG_LVL_LOW |-> !genFinal[0];
    endproperty
    a_held_low: assert property (p_held_low)
        else $error("held low force ignored");
    property p_divider;
        chTick && st_r.chCfg[`POG_CH_DIV] == 4'h1 && !$changed(st_r.chCfg) |=> !chTick ##1 chTick;
    endproperty
    a_divider: assert property (p_divider)
        else $error("carrier period wrong");

endmodule : pog_operator
`default_nettype wire

// ==== pog_params.svh ====
`ifndef POG_PARAMS_SVH
`define POG_PARAMS_SVH

// register byte offsets
`define POG_OFF_FH_CTRL    8'hA4
`define POG_OFF_FH_STATE   8'hA8
`define POG_OFF_STAMP_CTRL 8'hAC
`define POG_OFF_STAMP_A    8'hB0
`define POG_OFF_STAMP_B    8'hB4
`define POG_OFF_SRC        8'hB8
`define POG_OFF_FORCE      8'hBC
`define POG_OFF_ACT_A      8'hC0
`define POG_OFF_ACT_B      8'hC4
`define POG_OFF_DT_CFG     8'hC8
`define POG_OFF_DT_FALL    8'hCC
`define POG_OFF_DT_RISE    8'hD0
`define POG_OFF_CHOP       8'hD4

// fault handler software control
`define POG_FH_FORCE_SINGLE 0
`define POG_FH_FORCE_CYCLE  1
`define POG_FH_REFRESH      3:2
`define POG_FH_REF_ZERO     2
`define POG_FH_REF_PERIOD   3
`define POG_FH_CLEAR_SINGLE 4
`define POG_FH_CTRL         4:0

// time stamp update control
`define POG_STAMP_WHEN      7:0
`define POG_STAMP_WHEN_W    4
`define POG_STAMP_PEND      9:8

// event source config
`define POG_SRC_WHEN        3:0
`define POG_SRC_T0          6:4
`define POG_SRC_T1          9:7
`define POG_SRC_CFG         9:0
`define POG_SRC_SYNC        3'h3

// software force
`define POG_HELD_WHEN       5:0
`define POG_HELD_BASE       6
`define POG_OS_TRIG_BASE    10
`define POG_OS_STRIDE       3
`define POG_FORCE           15:0

// action tables: up events in the low half, down events from here
`define POG_ACT_DOWN        12
`define POG_ACT             23:0
`define POG_LVL_LOW         2'h1
`define POG_LVL_HIGH        2'h2
`define POG_ACT_TOGGLE      2'h3

// dead-time config
`define POG_DT_FALL_WHEN    3:0
`define POG_DT_RISE_WHEN    7:4
`define POG_DT_DEB          8
`define POG_DT_SWAP_A       9
`define POG_DT_SWAP_B       10
`define POG_DT_RISE_SRC     11
`define POG_DT_FALL_SRC     12
`define POG_DT_RISE_INV     13
`define POG_DT_FALL_INV     14
`define POG_DT_BYP_A        15
`define POG_DT_BYP_B        16
`define POG_DT_CLK_SEL      17
`define POG_DT_CFG          17:0
`define POG_DT_RESET        18'h18000

// chopper config
`define POG_CH_EN           0
`define POG_CH_DIV          4:1
`define POG_CH_DUTY         7:5
`define POG_CH_FIRST        11:8
`define POG_CH_OUT_INV      12
`define POG_CH_IN_INV       13
`define POG_CH_CFG          13:0

`endif

// ==== pog_pkg.sv ====
package pog_pkg;

    // timer and event inputs, all from logic on ref_clk
    typedef struct packed {
        logic [15:0] value;
        logic        countsDown;
        logic        zeroEvent;
        logic        periodEvent;
        logic        syncTaken;
        logic [2:0]  faultInput;
        logic        prescaledTick;
    } pog_timer_s;

    // complete register state of the operator
    typedef struct packed {
        logic [31:0]      rdata;
        logic [4:0]       fhCtrl;
        logic             singleTripActive;
        logic             perCycleTripActive;
        logic [7:0]       stampWhen;
        logic [1:0][15:0] stampShadow;
        logic [1:0][15:0] stampActive;
        logic [1:0]       stampPending;
        logic [9:0]       srcCfg;
        logic [15:0]      forceCfg;
        logic [3:0]       heldActive;
        logic [1:0][23:0] actShadow;
        logic [1:0][23:0] actActive;
        logic [17:0]      dtCfg;
        logic [1:0][15:0] delayShadow;
        logic [1:0][15:0] delayActive;
        logic [1:0][15:0] delayCnt;
        logic [1:0]       delayOut;
        logic [13:0]      chCfg;
        logic [3:0]       preCnt;
        logic [2:0]       phase;
        logic [1:0][3:0]  firstCnt;
        logic [1:0]       chInPrev;
        logic [1:0]       genOut;
        logic [1:0]       pwmOut;
        logic [1:0]       cmpEvent;
    } pog_state_s;

endpackage : pog_pkg

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pog_params.svh"

module tb;
    import pog_pkg::*;

    logic        ref_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic [7:0]  regAddr    = 8'h00;
    logic [31:0] regWdata   = 32'h0;
    logic        regWrite   = 1'b0;
    logic        regRead    = 1'b0;
    logic [31:0] regRdata;
    pog_timer_s  timerIn    = '0;
    logic        outA;
    logic        outB;
    logic        cmpA;
    logic        cmpB;
    logic        tripS;
    logic        tripC;
    int          bad_count  = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    pog_operator uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timerIn(timerIn),
        .operatorOutA(outA), .operatorOutB(outB), .compareAEvent(cmpA), .compareBEvent(cmpB),
        .singleTripActive(tripS), .perCycleTripActive(tripC)
    );

    always #4 ref_clk = ~ref_clk;

    // hang guard: whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr

    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask : rd

    // one-cycle pulse on {zero, period, sync, fault[2:0]}
    task automatic ev(input logic [5:0] m);
        @(posedge ref_clk);
        {timerIn.zeroEvent, timerIn.periodEvent, timerIn.syncTaken, timerIn.faultInput} <= m;
        @(posedge ref_clk);
        {timerIn.zeroEvent, timerIn.periodEvent, timerIn.syncTaken, timerIn.faultInput} <= '0;
    endtask : ev

    // outputs need up to three cycles after their cause; wait four
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : settle

    initial begin
        timerIn.value = 16'h1234;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`POG_OFF_FH_STATE, 32'h0);
        rd(`POG_OFF_DT_CFG, 32'h18000);
        rd(8'h10, 32'h0);
        // trip start, status, cancel
        wr(`POG_OFF_FH_CTRL, 32'h01);
        rd(`POG_OFF_FH_STATE, 32'h1);
        chk(tripS, 1'b1);
        wr(`POG_OFF_FH_CTRL, 32'h11);
        rd(`POG_OFF_FH_STATE, 32'h0);
        chk(tripS, 1'b0);
        wr(`POG_OFF_FH_CTRL, 32'h17);
        rd(`POG_OFF_FH_STATE, 32'h2);
        chk(tripC, 1'b1);
        ev(6'h10);
        rd(`POG_OFF_FH_STATE, 32'h2);
        ev(6'h20);
        rd(`POG_OFF_FH_STATE, 32'h0);
        chk(tripC, 1'b0);
        // stamp A loads at timer zero, then compares
        wr(`POG_OFF_STAMP_CTRL, 32'h1);
        wr(`POG_OFF_STAMP_A, 32'h5);
        rd(`POG_OFF_STAMP_CTRL, 32'h101);
        ev(6'h20);
        rd(`POG_OFF_STAMP_CTRL, 32'h001);
        @(posedge ref_clk);
        timerIn.value <= 16'h0005;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(cmpA, 1'b1);
        chk(cmpB, 1'b0);
        @(posedge ref_clk) timerIn.value <= 16'h0000;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(cmpB, 1'b1);
        chk(cmpA, 1'b0);
        @(posedge ref_clk) timerIn.value <= 16'h1234;
        wr(`POG_OFF_STAMP_CTRL, 32'h8);
        wr(`POG_OFF_STAMP_A, 32'h7);
        ev(6'h20);
        rd(`POG_OFF_STAMP_CTRL, 32'h108);
        // back to method zero: the blocked value loads at once
        wr(`POG_OFF_STAMP_CTRL, 32'h0);
        rd(`POG_OFF_STAMP_CTRL, 32'h000);
        // action tables, up and down
        wr(`POG_OFF_ACT_A, 32'hC002);
        ev(6'h20);
        settle();
        chk(outA, 1'b1);
        @(posedge ref_clk) timerIn.countsDown <= 1'b1;
        ev(6'h10);
        settle();
        chk(outA, 1'b0);
        @(posedge ref_clk) timerIn.countsDown <= 1'b0;
        // t0 from fault input one, then from nothing
        wr(`POG_OFF_SRC, 32'h10);
        wr(`POG_OFF_ACT_A, 32'h102);
        ev(6'h20);
        ev(6'h02);
        settle();
        chk(outA, 1'b0);
        wr(`POG_OFF_SRC, 32'h40);
        ev(6'h20);
        ev(6'h02);
        settle();
        chk(outA, 1'b1);
        // one-time force low, then held force on B
        wr(`POG_OFF_FORCE, 32'hC00);
        settle();
        chk(outA, 1'b0);
        wr(`POG_OFF_FORCE, 32'hE00);
        settle();
        chk(outB, 1'b1);
        wr(`POG_OFF_FORCE, 32'hD41);
        settle();
        chk(outB, 1'b1);
        ev(6'h20);
        settle();
        chk(outB, 1'b0);
        chk(outA, 1'b0);
        rd(`POG_OFF_FORCE, 32'hD41);
        // a disabled chopper ignores the invert bit
        wr(`POG_OFF_CHOP, 32'h1000);
        settle();
        chk(outB, 1'b0);
        wr(`POG_OFF_CHOP, 32'h1003);
        settle();
        chk(outB, 1'b1);
        rd(`POG_OFF_CHOP, 32'h1003);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
